// File: rtl/fljl_pkg.sv
// What this block does
// - time each continuous DO transmission; declare jabber past a fixed 20-150 ms limit
// - on jabber cut DO to fiber and send optical idle in the same cycle, then CS0 on CI
// - jabber state clears on power reset and CI returns to IDL
// - optionally clear jabber after 0.5 s of continuous DO inactivity
// - jabber limit exceeds the longest output a repeater legally sends
// - jabber behaviour overrides low-light behaviour on CI
// - low light stops passing received optical idle and packets to repeater
// - receive path to DI disabled 30 to 200 bit times after low light
// - during lockout only optical idle goes into the transmit fiber
// - during lockout a DO packet is not looped back onto DI
// - after low light clears, resume within 40 bit times once DO idle
// - forward each bit to DI as CD0 or CD1, without retiming
// - with nothing to forward, DI carries IDL
// - CI shows IDL when available, also during lockout without an error
// - no signal_quality_error test sequence after a transmitted packet
// - simultaneous transmit and receive packets drive CS0 on CI
// - signal_quality_error can be raised whenever powered, not only with DO active
// - four separate path enables: fiber driver, idle generator, loopback, receive
// - packet timer runs while DO active, stops at idle, expiry means jabber
// - unjab timer runs while DO idle, stops when output resumes
// - collision on CI within 3.5 bit times, drops 4.5 to 7 after
package fljl_pkg;
    // clock and bit rate
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned BIT_TIME_NS   = 100;
    localparam int unsigned BIT_CYCLES    = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_W        = 4;

    // long timers, in their own units and in cycles
    localparam int unsigned TMR_W            = 26;
    localparam int unsigned JAB_LIMIT_MS     = 26;
    localparam int unsigned JAB_LIMIT_CYCLES = JAB_LIMIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int unsigned UNJAB_MS         = 500;
    localparam int unsigned UNJAB_CYCLES     = UNJAB_MS * 1000000 / CLK_PERIOD_NS;

    // collision hold after the condition ends
    localparam int unsigned COL_HOLD_NS     = 550;
    localparam int unsigned COL_HOLD_CYCLES = (COL_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned COL_W           = 7;

    // low-light windows in bit times
    localparam int unsigned LL_W        = 8;
    localparam int unsigned LL_ACT_BITS = 64;
    localparam int unsigned LL_CLR_BITS = 16;

    // register map
    localparam int unsigned AXI_AW     = 4;
    localparam logic [3:0]  REG_CTRL   = 4'h0;
    localparam logic [3:0]  REG_STATUS = 4'h4;
    localparam int unsigned CTRL_AUTO  = 0;
    localparam int unsigned CTRL_CLEAR = 1;
    localparam logic        CTRL_AUTO_RST = 1'b1;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        JAB_RUN   = 4'h1,
        JAB_CUT   = 4'h2,
        JAB_HOLD  = 4'h4,
        JAB_QUIET = 4'h8
    } fljl_jab_t;

    typedef enum logic [3:0] {
        LL_OK   = 4'h1,
        LL_ARM  = 4'h2,
        LL_LOCK = 4'h4,
        LL_REL  = 4'h8
    } fljl_ll_t;
endpackage

// File: rtl/fljl_bit_tick.sv
`timescale 1ns/1ps
module fljl_bit_tick (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // one pulse per bit time
    output logic      tick
);
    import fljl_pkg::*;

    localparam logic [TICK_W-1:0] LAST = TICK_W'(BIT_CYCLES - 1);

    logic [TICK_W-1:0] cnt_q;
    logic              wrap;

    assign wrap = (cnt_q == LAST);
    assign tick = wrap;

    // free-running bit-rate divider
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= wrap ? '0 : cnt_q + 1'b1;
        end
    end
endmodule

// File: rtl/fljl_timer.sv
`timescale 1ns/1ps
module fljl_timer #(
    parameter int unsigned LIMIT = 4096
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // control
    input  wire logic run,
    input  wire logic clear,
    // expiry level, held until clear
    output logic      done
);
    import fljl_pkg::*;

    localparam logic [TMR_W-1:0] LAST = TMR_W'(LIMIT - 1);

    logic [TMR_W-1:0] cnt_q;

    assign done = (cnt_q == LAST);

    // saturating so expiry stays visible while run holds
    always_ff @(posedge clk) begin
        if (!rst_b || clear) begin
            cnt_q <= '0;
        end else if (run && !done) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end
endmodule

// File: rtl/fljl_ctrl.sv
`timescale 1ns/1ps
module fljl_ctrl #(
    parameter int unsigned JAB_LIMIT = fljl_pkg::JAB_LIMIT_CYCLES,
    parameter int unsigned UNJAB_LIM = fljl_pkg::UNJAB_CYCLES
) (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    // axi4-lite write address and data
    input  wire logic [fljl_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    // axi4-lite read
    input  wire logic [fljl_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    // repeater output circuit, decoded
    input  wire logic                        do_active,
    input  wire logic                        do_bit,
    // receive fiber, decoded
    input  wire logic                        rx_active,
    input  wire logic                        rx_bit,
    input  wire logic                        weak_light_present,
    // repeater input and control circuits
    output logic                             di_active,
    output logic                             di_bit,
    output logic                             ci_cs0,
    // transmit fiber
    output logic                             fiber_tx_bit,
    // path enables
    output logic                             tx_data_en,
    output logic                             tx_idle_en,
    output logic                             loopback_en,
    output logic                             rx_path_en,
    // exterior indicators
    output logic                             jabber_active,
    output logic                             lockout_active
);
    import fljl_pkg::*;

    localparam logic [LL_W-1:0]  LL_ACT_LAST = LL_W'(LL_ACT_BITS - 1);
    localparam logic [LL_W-1:0]  LL_CLR_LAST = LL_W'(LL_CLR_BITS - 1);
    localparam logic [COL_W-1:0] COL_LOAD    = COL_W'(COL_HOLD_CYCLES);

    // register decode shared by the read and write sides
    function automatic logic reg_mapped(input logic [AXI_AW-1:0] a);
        return (a == REG_CTRL) || (a == REG_STATUS);
    endfunction

    fljl_jab_t         jab_q;
    fljl_jab_t         jab_d;
    fljl_ll_t          ll_q;
    fljl_ll_t          ll_d;
    logic [LL_W-1:0]   ll_cnt_q;
    logic [LL_W-1:0]   ll_cnt_d;
    logic [COL_W-1:0]  col_cnt_q;
    logic [COL_W-1:0]  col_cnt_d;
    logic              bit_tick;
    logic              pkt_run;
    logic              pkt_clear;
    logic              pkt_done;
    logic              unjab_run;
    logic              unjab_clear;
    logic              unjab_done;
    logic              jab_cut;
    logic              jab_sqe;
    logic              ll_lock;
    logic              col_cond;
    logic              col_on;
    logic              sel_lb_q;
    logic              sel_rx_q;
    logic              sel_lb_d;
    logic              sel_rx_d;
    logic              auto_unjab_q;
    logic              soft_clear_q;
    logic              aw_hold_q;
    logic              w_hold_q;
    logic [AXI_AW-1:0] aw_addr_q;
    logic [31:0]       w_data_q;
    logic [3:0]        w_strb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              rvalid_q;
    logic [1:0]        rresp_q;
    logic [31:0]       rdata_q;
    logic              wr_fire;
    logic              ar_fire;
    logic              ctrl_wr;
    logic [31:0]       ctrl_word;
    logic [31:0]       status_word;
    logic [31:0]       rd_word;

    fljl_bit_tick u_tick (
        .clk   (clk),
        .rst_b (rst_b),
        .tick  (bit_tick)
    );

    assign pkt_run   = do_active && (jab_q == JAB_RUN);
    assign pkt_clear = !do_active;

    fljl_timer #(
        .LIMIT (JAB_LIMIT)
    ) u_pkt_tmr (
        .clk   (clk),
        .rst_b (rst_b),
        .run   (pkt_run),
        .clear (pkt_clear),
        .done  (pkt_done)
    );

    assign unjab_run   = !do_active && (jab_q == JAB_QUIET);
    assign unjab_clear = do_active || (jab_q != JAB_QUIET);

    fljl_timer #(
        .LIMIT (UNJAB_LIM)
    ) u_unjab_tmr (
        .clk   (clk),
        .rst_b (rst_b),
        .run   (unjab_run),
        .clear (unjab_clear),
        .done  (unjab_done)
    );

    // jabber next state; soft clear only while DO is quiet
    always_comb begin
        jab_d = jab_q;
        unique case (jab_q)
            JAB_RUN: begin
                if (pkt_done) begin
                    jab_d = JAB_CUT;
                end
            end
            JAB_CUT: begin
                // data already cut and idle already on, cs0 follows
                jab_d = JAB_HOLD;
            end
            JAB_HOLD: begin
                if (!do_active) begin
                    jab_d = JAB_QUIET;
                end
            end
            JAB_QUIET: begin
                if (do_active) begin
                    jab_d = JAB_HOLD;
                end else if (auto_unjab_q && unjab_done) begin
                    jab_d = JAB_RUN;
                end else if (soft_clear_q) begin
                    jab_d = JAB_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            jab_q <= JAB_RUN;
        end else begin
            jab_q <= jab_d;
        end
    end

    // cut and idle together, cs0 on CI two cycles later
    assign jab_cut = (jab_q != JAB_RUN);
    assign jab_sqe = (jab_q == JAB_HOLD) || (jab_q == JAB_QUIET);

    // low-light next state with a shared bit counter
    always_comb begin
        ll_d     = ll_q;
        ll_cnt_d = ll_cnt_q;
        unique case (ll_q)
            LL_OK: begin
                ll_cnt_d = '0;
                if (weak_light_present) begin
                    ll_d = LL_ARM;
                end
            end
            LL_ARM: begin
                // lock after 64 bit times, inside 30..200
                if (!weak_light_present) begin
                    ll_d = LL_OK;
                end else if (bit_tick && ll_cnt_q == LL_ACT_LAST) begin
                    ll_d     = LL_LOCK;
                    ll_cnt_d = '0;
                end else if (bit_tick) begin
                    ll_cnt_d = ll_cnt_q + 1'b1;
                end
            end
            LL_LOCK: begin
                ll_cnt_d = '0;
                if (!weak_light_present && !do_active) begin
                    ll_d = LL_REL;
                end
            end
            LL_REL: begin
                // release after 16 quiet bit times, under 40
                if (weak_light_present || do_active) begin
                    ll_d     = LL_LOCK;
                    ll_cnt_d = '0;
                end else if (bit_tick && ll_cnt_q == LL_CLR_LAST) begin
                    ll_d = LL_OK;
                end else if (bit_tick) begin
                    ll_cnt_d = ll_cnt_q + 1'b1;
                end
            end
        endcase
    end

    // low-light state registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ll_q     <= LL_OK;
            ll_cnt_q <= '0;
        end else begin
            ll_q     <= ll_d;
            ll_cnt_q <= ll_cnt_d;
        end
    end

    assign ll_lock = (ll_q == LL_LOCK) || (ll_q == LL_REL);

    // jabber cut wins regardless of lockout
    assign tx_data_en  = !jab_cut && !ll_lock;
    // idle generator whenever no data is driven
    assign tx_idle_en  = !(tx_data_en && do_active);
    // no loopback of DO packets while locked out
    assign loopback_en = !ll_lock;
    // receive path closed while locked out
    assign rx_path_en  = !ll_lock;

    // packets at both fiber ends at once
    assign col_cond = tx_data_en && do_active && rx_active && rx_path_en;

    // raise next cycle, hold 55 cycles after the end
    always_comb begin
        if (col_cond) begin
            col_cnt_d = COL_LOAD;
        end else if (col_cnt_q != '0) begin
            col_cnt_d = col_cnt_q - 1'b1;
        end else begin
            col_cnt_d = '0;
        end
    end

    // collision hold counter
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            col_cnt_q <= '0;
        end else begin
            col_cnt_q <= col_cnt_d;
        end
    end

    assign col_on = (col_cnt_q != '0);

    // first source to arrive owns DI until it goes idle
    always_comb begin
        sel_lb_d = sel_lb_q && do_active && loopback_en;
        sel_rx_d = sel_rx_q && rx_active && rx_path_en;
        if (!sel_lb_d && !sel_rx_d) begin
            // simultaneous arrival picks loopback
            sel_lb_d = do_active && loopback_en;
            sel_rx_d = !sel_lb_d && rx_active && rx_path_en;
        end
    end

    // DI, CI and fiber data flops; one clock of delay, no bit retiming
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sel_lb_q     <= 1'b0;
            sel_rx_q     <= 1'b0;
            di_active    <= 1'b0;
            di_bit       <= 1'b0;
            ci_cs0       <= 1'b0;
            fiber_tx_bit <= 1'b0;
        end else begin
            sel_lb_q     <= sel_lb_d;
            sel_rx_q     <= sel_rx_d;
            di_active    <= sel_lb_d || sel_rx_d;
            // symbol follows the selected source bit
            di_bit       <= sel_lb_d ? do_bit : (sel_rx_d && rx_bit);
            // cs0 only from collision or jabber
            ci_cs0       <= jab_sqe || col_on;
            fiber_tx_bit <= tx_data_en && do_bit;
        end
    end

    assign jabber_active  = jab_cut;
    assign lockout_active = ll_lock;

    // bus handshakes; one write and one read in flight
    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready  = !w_hold_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign wr_fire       = aw_hold_q && w_hold_q && !bvalid_q;
    assign ar_fire       = s_axi_arvalid && !rvalid_q;
    assign ctrl_wr       = wr_fire && (aw_addr_q == REG_CTRL) && w_strb_q[0];

    // address and data may arrive in either order
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_addr_q <= '0;
            w_data_q  <= '0;
            w_strb_q  <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    // write response; status writes are accepted and ignored
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= reg_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // control bits; clear request is a self-clearing pulse
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            auto_unjab_q <= CTRL_AUTO_RST;
            soft_clear_q <= 1'b0;
        end else begin
            soft_clear_q <= ctrl_wr && w_data_q[CTRL_CLEAR];
            if (ctrl_wr) begin
                auto_unjab_q <= w_data_q[CTRL_AUTO];
            end
        end
    end

    // read words
    assign ctrl_word   = {30'h0, 1'b0, auto_unjab_q};
    assign status_word = {22'h0, rx_active, do_active, rx_path_en, loopback_en,
                          tx_idle_en, tx_data_en, weak_light_present, col_on,
                          ll_lock, jab_cut};
    assign rd_word     = (s_axi_araddr == REG_CTRL)   ? ctrl_word :
                         (s_axi_araddr == REG_STATUS) ? status_word : 32'h0;

    // read data captured at the address handshake
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= '0;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rresp_q  <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_q  <= rd_word;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp  = rresp_q;
    assign s_axi_rdata  = rdata_q;
endmodule

// File: verif/fljl_ctrl_properties.sv
`timescale 1ns/1ps
module fljl_ctrl_properties #(
    parameter int unsigned JAB_LIMIT = 200
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // link inputs
    input wire logic do_active,
    input wire logic do_bit,
    input wire logic rx_active,
    input wire logic weak_light_present,
    // link outputs
    input wire logic di_active,
    input wire logic di_bit,
    input wire logic ci_cs0,
    input wire logic fiber_tx_bit,
    input wire logic tx_data_en,
    input wire logic loopback_en,
    input wire logic rx_path_en,
    input wire logic jabber_active,
    input wire logic lockout_active
);
    logic [31:0] do_n_q, wl_n_q, qt_n_q;
    logic [6:0]  gap_q;
    wire         col_c = tx_data_en & do_active & rx_active & rx_path_en;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // run lengths; gap saturates so a long quiet line never wraps
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            {do_n_q, wl_n_q, qt_n_q, gap_q} <= {96'h0, 7'h7f};
        end else begin
            do_n_q <= do_active ? do_n_q + 32'h1 : 32'h0;
            wl_n_q <= weak_light_present ? wl_n_q + 32'h1 : 32'h0;
            qt_n_q <= (weak_light_present | do_active) ? 32'h0 : qt_n_q + 32'h1;
            gap_q  <= col_c ? 7'h0 : gap_q + {6'h0, gap_q != 7'h7f};
        end
    end

    a_jab_early: assert property ($rose(jabber_active) |-> do_n_q + 2 >= JAB_LIMIT)
        else $error("jabber too early");
    a_jab_late: assert property (do_n_q == JAB_LIMIT + 4 |-> jabber_active)
        else $error("jabber missed");
    a_jab_order: assert property ($rose(jabber_active) |-> !tx_data_en ##[1:3] ci_cs0)
        else $error("jabber order");
    a_jab_cs0: assert property (jabber_active [*4] |-> ci_cs0)
        else $error("jabber lost cs0");
    a_lock_paths: assert property ($rose(lockout_active) |->
        !rx_path_en && !loopback_en && !tx_data_en) else $error("lockout paths open");
    a_lock_delay: assert property ($rose(lockout_active) |-> wl_n_q inside {[300:2000]})
        else $error("lockout delay");
    a_lock_clear: assert property (qt_n_q == 400 |-> !lockout_active)
        else $error("lockout stuck");
    a_col_rise: assert property ($rose(col_c) |-> ##[1:35] ci_cs0)
        else $error("collision late");
    a_col_drop: assert property (gap_q == 7'd71 && !jabber_active |-> !ci_cs0)
        else $error("collision stuck");
    a_loop_bits: assert property (do_active && !rx_active && loopback_en |=>
        di_active && di_bit == $past(do_bit)) else $error("loopback bit");
    a_fiber_bits: assert property (tx_data_en |=> fiber_tx_bit == $past(do_bit))
        else $error("fiber bit");
    c_jab: cover property ($rose(jabber_active));
    c_lock: cover property ($rose(lockout_active));
    c_col: cover property ($rose(col_c));
endmodule

bind fljl_ctrl fljl_ctrl_properties #(.JAB_LIMIT(JAB_LIMIT)) u_fljl_ctrl_properties (.*);

// File: verif/fljl_rep_model.sv
`timescale 1ns/1ps
module fljl_rep_model (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // burst length in cycles
    input  wire logic        go,
    input  wire logic [31:0] len,
    // repeater output circuit
    output logic             do_active,
    output logic             do_bit
);
    logic [31:0] left_q = 32'h0;
    logic [7:0]  ph_q = 8'h0;

    // repeater symbol drive
    // idle line keeps toggling so no stale bit looks like data
    assign do_active = left_q != 32'h0;
    assign do_bit    = do_active ? ph_q[0] ^ ph_q[3] : ph_q[0];

    // burst countdown
    always @(posedge clk) begin
        ph_q <= ph_q + 8'h1;
        if (!rst_b) begin
            left_q <= 32'h0;
        end else if (go) begin
            left_q <= len;
        end else if (do_active) begin
            left_q <= left_q - 32'h1;
        end
    end
endmodule

// File: verif/fljl_ctrl_bench.sv
`timescale 1ns/1ps
module fljl_ctrl_bench;
    import fljl_pkg::*;
    localparam int JL = 200;
    localparam int UL = 300;
    logic        clk, rst_b, go, rx_active, weak_light_present;
    logic        rx_bit = 1'b0;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        do_active, do_bit, di_active, di_bit, ci_cs0, fiber_tx_bit, tx_data_en;
    logic        tx_idle_en, loopback_en, rx_path_en, jabber_active, lockout_active;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, len;
    int          errors, checks;
    wire  [3:0]  flags = {do_active, ci_cs0, lockout_active, jabber_active};

    fljl_ctrl #(.JAB_LIMIT(JL), .UNJAB_LIM(UL)) u_fljl_ctrl (.*);
    fljl_rep_model u_fljl_rep_model (.*);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // rx bit toggles each cycle to expose a late forward
    always @(posedge clk) rx_bit <= ~rx_bit;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic hang;
        errors++;
        give_verdict();
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bounded wait on one indicator
    task automatic waitf(input int i, input logic v, input int lim);
        for (int n = 0; flags[i] !== v; n++) begin
            if (n == lim) hang();
            @(posedge clk);
        end
    endtask
    task automatic burst(input int n);
        go <= 1'b1;
        len <= n;
        cyc(1);
        go <= 1'b0;
        cyc(1);
    endtask
    // write: aw and w together, each dropped once taken
    task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        int n = 0;
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 50);
        s_axi_bready <= 1'b0;
        r = s_axi_bresp;
        if (n == 50) hang();
    endtask
    task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n = 0;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid && n < 50);
        s_axi_rready <= 1'b0;
        {d, r} = {s_axi_rdata, s_axi_rresp};
        if (n == 50) hang();
    endtask

    task automatic t_regs;
        logic [31:0] d;
        logic [1:0]  r;
        axr(REG_CTRL, d, r);
        chk("ctrl", 32'h1, d);
        axr(REG_STATUS, d, r);
        chk("status", 32'hf0, d);
        axr(4'h8, d, r);
        chk("rd_unmapped", RESP_SLVERR, r);
        axw(4'hc, 32'h1, r);
        chk("wr_unmapped", RESP_SLVERR, r);
    endtask
    task automatic t_jab;
        burst(JL - 20);
        waitf(3, 1'b0, JL);
        cyc(20);
        chk("jab_short", 0, jabber_active);
        chk("no_sqe", 0, ci_cs0);
        burst(3 * JL);
        waitf(0, 1'b1, JL + 20);
        cyc(3);
        chk("tx_cut", 0, tx_data_en);
        chk("tx_idle", 1, tx_idle_en);
        waitf(3, 1'b0, 3 * JL);
        cyc(UL / 2);
        chk("jab_held", 1, jabber_active);
        chk("sqe_no_do", 1, ci_cs0);
        waitf(0, 1'b0, UL);
        cyc(2);
        chk("ci_idl", 0, ci_cs0);
    endtask
    task automatic t_soft;
        logic [1:0] r;
        axw(REG_CTRL, 32'h0, r);
        burst(2 * JL);
        waitf(0, 1'b1, JL + 20);
        waitf(3, 1'b0, 2 * JL);
        cyc(UL + 50);
        chk("no_auto", 1, jabber_active);
        axw(REG_CTRL, 32'h2, r);
        cyc(3);
        chk("soft_clr", 0, {jabber_active, ci_cs0});
        burst(2 * JL);
        waitf(0, 1'b1, JL + 20);
        waitf(3, 1'b0, 2 * JL);
        rst_b <= 1'b0;
        cyc(2);
        rst_b <= 1'b1;
        cyc(1);
        chk("pwr_clr", 0, {jabber_active, ci_cs0});
    endtask
    task automatic t_lock;
        weak_light_present <= 1'b1;
        cyc(280);
        chk("rx_early", 1, rx_path_en);
        waitf(1, 1'b1, 2000);
        cyc(2);
        chk("paths_off", 0, {rx_path_en, loopback_en});
        rx_active <= 1'b1;
        burst(2 * JL);
        cyc(20);
        chk("di_shut", 0, di_active);
        chk("fiber_idle", 0, fiber_tx_bit);
        chk("avail", 0, ci_cs0);
        rx_active <= 1'b0;
        waitf(0, 1'b1, 2 * JL);
        cyc(4);
        chk("jab_over", 1, ci_cs0);
        weak_light_present <= 1'b0;
        waitf(3, 1'b0, 2 * JL);
        waitf(1, 1'b0, 400);
        waitf(0, 1'b0, 2 * UL);
    endtask
    task automatic t_coll;
        int   n = 0;
        logic p;
        rx_active <= 1'b1;
        cyc(4);
        p = rx_bit;
        repeat (6) begin
            @(posedge clk);
            chk("di_rx", {1'b1, p}, {di_active, di_bit});
            p = rx_bit;
        end
        burst(150);
        waitf(2, 1'b1, 40);
        rx_active <= 1'b0;
        for (n = 0; ci_cs0 === 1'b1 && n < 100; n++) @(posedge clk);
        chk("col_hold", 1, n >= 44 && n <= 71);
        waitf(3, 1'b0, 200);
        cyc(3);
        chk("di_idl", 0, di_active);
    endtask

    initial begin
        {rst_b, go, rx_active, weak_light_present, len} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {40'h0, 4'hf};
        {errors, checks} = '0;
        cyc(10);
        rst_b <= 1'b1;
        cyc(1);
        t_regs();
        t_jab();
        t_soft();
        t_lock();
        t_coll();
        give_verdict();
    end
    // overall watchdog
    initial begin
        cyc(20000);
        hang();
    end
endmodule
